//--- sim/mas_front_model.sv
// Front end model: encoder index, sensor ok flags, measurement value
`timescale 1ns/1ps
`default_nettype none
module mas_front_model #(
  parameter logic [31:0] MEAS_VAL = 32'h0000_0001
) (
  input  wire logic        clk,
  input  wire logic        spin,
  input  wire logic [2:0]  ok_mask,
  output logic             index_pin,
  output logic [2:0]       sensor_ok_pin,
  output logic [31:0]      meas_data
);
  logic [3:0] ang_r = 4'h0;
  always @(posedge clk) ang_r <= ang_r + 4'h1;
  // sensors sit on the motor shaft, no gear ratio or feed needed
  // Index pulse 4 of 16 cycles while turning
  always_comb index_pin = spin && (ang_r < 4'h4);
  always_comb sensor_ok_pin = ok_mask;
  always_comb meas_data = MEAS_VAL;
endmodule : mas_front_model
`default_nettype wire

//--- sim/mas_sequencer_props.sv
// Checker of the auto setup sequencer ports
`timescale 1ns/1ps
`default_nettype none
module mas_sequencer_props (
  input wire logic        CLK,
  input wire logic        NRST,
  input wire logic [7:0]  ADDR,
  input wire logic [31:0] WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [31:0] RDATA,
  input wire logic        STORE_REQ,
  input wire logic [7:0]  STORE_SUBIDX,
  input wire logic [1:0]  COMMUT_SEL,
  input wire logic [1:0]  VEL_SEL,
  input wire logic [1:0]  POS_SEL,
  input wire logic [1:0]  OL_SEL,
  input wire logic        IRQ
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  logic       mode_fe_r;
  logic [1:0] mask_r;
  logic [1:0] selwr_r;
  // Track mode, mask and selection writes
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      mode_fe_r <= 1'b0;
      mask_r    <= 2'b00;
      selwr_r   <= 2'b00;
    end else begin
      if (WR && ADDR == 8'h00) mode_fe_r <= (WDATA[7:0] == 8'hFE);
      if (WR && ADDR == 8'h24) mask_r <= WDATA[1:0];
      selwr_r <= {selwr_r[0], WR && (ADDR == 8'h1C || ADDR == 8'h10 || ADDR == 8'h14 || ADDR == 8'h18)};
    end
  end
  sequence s_store_rd;
    STORE_REQ ##1 (RD && ADDR == 8'h08);
  endsequence
  property p_sel_map;
    logic [7:0] d;
    (WR && ADDR == 8'h1C, d = WDATA[7:0]) |-> ##2 ({OL_SEL, POS_SEL, VEL_SEL, COMMUT_SEL} == d);
  endproperty
  AST_RDATA_IDLE: assert property (!$past(RD) |-> RDATA == 32'h0000_0000)
    else $error("read data not zero outside read answer");
  AST_STORE_PULSE: assert property (STORE_REQ |=> !STORE_REQ)
    else $error("store request longer than one cycle");
  AST_STORE_SUBIDX: assert property (STORE_REQ |-> STORE_SUBIDX[6:5] == 2'b11)
    else $error("store categories missing at store request");
  AST_SUBIDX_HOLD: assert property (STORE_SUBIDX[6:5] == 2'b11 |=> STORE_SUBIDX[6:5] == 2'b11)
    else $error("store categories dropped");
  AST_STORE_MODE: assert property (STORE_REQ |-> mode_fe_r)
    else $error("run completed outside setup mode");
  AST_DONE_AFTER_STORE: assert property (s_store_rd |=> RDATA[12])
    else $error("done bit not set after store");
  AST_SEL_MAP: assert property (p_sel_map)
    else $error("loop selection outputs differ from write");
  AST_SEL_STABLE: assert property ($changed({OL_SEL, POS_SEL, VEL_SEL, COMMUT_SEL}) |-> |selwr_r)
    else $error("loop selection changed without write");
  AST_IRQ_MASKED: assert property ((mask_r == 2'b00) [*3] |-> !IRQ)
    else $error("interrupt high while fully masked");
endmodule : mas_sequencer_props
bind mas_sequencer mas_sequencer_props mas_sequencer_props_inst (.CLK(CLK), .NRST(NRST), .ADDR(ADDR),
  .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .STORE_REQ(STORE_REQ), .STORE_SUBIDX(STORE_SUBIDX),
  .COMMUT_SEL(COMMUT_SEL), .VEL_SEL(VEL_SEL), .POS_SEL(POS_SEL), .OL_SEL(OL_SEL), .IRQ(IRQ));
`default_nettype wire

//--- sim/mas_sequencer_tb.sv
// Self-checking testbench of the auto setup sequencer
`timescale 1ns/1ps
`default_nettype none
module mas_sequencer_tb;
  localparam logic [31:0] MV = 32'h0000_5A3C;
  logic        CLK, NRST, WR, RD, OP_ENABLED, INDEX_PIN, STORE_REQ, IRQ, spin;
  logic [7:0]  ADDR, STORE_SUBIDX;
  logic [31:0] WDATA, RDATA, MEAS_DATA, d;
  logic [2:0]  SENSOR_OK_PIN, ok_mask;
  logic [1:0]  COMMUT_SEL, VEL_SEL, POS_SEL, OL_SEL;
  int          n_errors, compares;

  always #10 CLK = ~CLK;

  mas_sequencer #(.CHECK_CYC(40), .STAGE_CYC(20)) mas_sequencer_inst (.CLK(CLK), .NRST(NRST), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .OP_ENABLED(OP_ENABLED), .INDEX_PIN(INDEX_PIN),
    .SENSOR_OK_PIN(SENSOR_OK_PIN), .MEAS_DATA(MEAS_DATA), .STORE_REQ(STORE_REQ), .STORE_SUBIDX(STORE_SUBIDX),
    .COMMUT_SEL(COMMUT_SEL), .VEL_SEL(VEL_SEL), .POS_SEL(POS_SEL), .OL_SEL(OL_SEL), .IRQ(IRQ));
  mas_front_model #(.MEAS_VAL(MV)) mas_front_model_inst (.clk(CLK), .spin(spin), .ok_mask(ok_mask),
    .index_pin(INDEX_PIN), .sensor_ok_pin(SENSOR_OK_PIN), .meas_data(MEAS_DATA));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge CLK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= v;
    @(posedge CLK);
    WR <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge CLK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge CLK);
    RD <= 1'b0;
    #1 d = RDATA;
  endtask : rd
  task automatic t_sensor;
    for (int a = 8'h10; a <= 8'h18; a += 4) begin
      rd(a[7:0]);
      chk(d, 32'h0000_0001, "resolution reset");
    end
    rd(8'h3C);
    chk(d, 32'h0000_0000, "unmapped read");
    wr(8'h24, 32'h0000_0003);
    repeat (60) @(posedge CLK);
    rd(8'h08);
    chk(d[3], 1'b1, "fault bit");
    rd(8'h28);
    chk(d, 32'h0000_7302, "error code");
    rd(8'h20);
    chk(d, 32'h0000_0002, "error event");
    chk(IRQ, 1'b1, "error interrupt");
    wr(8'h20, 32'h0000_0002);
    rd(8'h20);
    chk(IRQ, 1'b0, "interrupt cleared");
    chk(d, 32'h0000_0000, "error event cleared");
    ok_mask <= 3'b111;
    $display("sensor check test done");
  endtask : t_sensor
  task automatic t_select;
    wr(8'h1C, 32'h0000_00E4);
    rd(8'h1C);
    chk({OL_SEL, POS_SEL, VEL_SEL, COMMUT_SEL}, 8'hE4, "loop selection");
    chk(d, 32'h0000_00E4, "selection readback");
    $display("selection test done");
  endtask : t_select
  task automatic t_run(input logic idx, input logic [31:0] cfg2);
    int i;
    wr(8'h00, 32'h0000_00FE);
    wr(8'h0C, 32'h0000_0000);
    OP_ENABLED <= 1'b1;
    spin <= idx;
    wr(8'h04, 32'h0000_0000);
    wr(8'h04, 32'h0000_0010);
    rd(8'h08);
    chk(d[12], 1'b0, "done at start");
    for (i = 0; i < 400 && STORE_REQ !== 1'b1; i++) @(posedge CLK);
    RD <= 1'b1;
    ADDR <= 8'h08;
    @(posedge CLK);
    RD <= 1'b0;
    #1 d = RDATA;
    chk(i < 400, 1'b1, "run finished");
    chk(d[12], 1'b1, "done bit");
    chk(d[10], idx, "index flag");
    chk(STORE_SUBIDX, 8'h60, "store categories");
    rd(8'h30);
    chk(d, MV, "sensorless result");
    rd(8'h34);
    chk(d, MV, "encoder 1 result");
    rd(8'h38);
    chk(d, cfg2, "encoder 2 result");
    chk(IRQ, 1'b1, "done interrupt");
    wr(8'h20, 32'h0000_0001);
    rd(8'h20);
    chk(IRQ, 1'b0, "done interrupt cleared");
    chk(d, 32'h0000_0000, "done event cleared");
    spin <= 1'b0;
    $display("setup run test done");
  endtask : t_run
  task automatic try_start;
    wr(8'h04, 32'h0000_0000);
    wr(8'h04, 32'h0000_0010);
    repeat (100) @(posedge CLK);
    rd(8'h08);
  endtask : try_start
  task automatic t_refuse;
    int i;
    NRST <= 1'b0;
    repeat (16) @(posedge CLK);
    NRST <= 1'b1;
    wr(8'h00, 32'h0000_0001);
    wr(8'h04, 32'h0000_0000);
    wr(8'h04, 32'h0000_0010);
    for (i = 0; i < 200 && STORE_REQ !== 1'b1; i++) @(posedge CLK);
    chk(i, 200, "run outside setup mode");
    rd(8'h08);
    chk(d[12], 1'b0, "done outside setup mode");
    wr(8'h00, 32'h0000_00FE);
    wr(8'h0C, 32'h0000_0001);
    try_start;
    chk(d[12], 1'b0, "run while program active");
    wr(8'h0C, 32'h0000_0000);
    OP_ENABLED <= 1'b0;
    try_start;
    chk(d[12], 1'b0, "run while not enabled");
    OP_ENABLED <= 1'b1;
    try_start;
    chk(d[12], 1'b1, "run once conditions hold");
    $display("refusal test done");
  endtask : t_refuse
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test

  initial begin
    CLK = 1'b0;
    NRST = 1'b0;
    WR = 1'b0;
    RD = 1'b0;
    ADDR = 8'h00;
    WDATA = 32'h0000_0000;
    OP_ENABLED = 1'b0;
    spin = 1'b0;
    ok_mask = 3'b011;
    n_errors = 0;
    compares = 0;
    repeat (16) @(posedge CLK);
    NRST <= 1'b1;
    t_sensor;
    t_select;
    t_run(1'b1, MV);
    // master sets resolution itself for index-less encoder
    wr(8'h14, 32'h0000_0800);
    rd(8'h14);
    chk(d, 32'h0000_0800, "resolution write");
    wr(8'h18, 32'h0000_0000);
    t_run(1'b0, 32'h0000_0000);
    t_refuse;
    finish_test;
  end
  initial begin
    repeat (5000) @(posedge CLK);
    n_errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    finish_test;
  end
endmodule : mas_sequencer_tb
`default_nettype wire

//--- verilog/mas_meas_engine.sv
// Measurement run engine: one stage per feedback, index pulse capture
`timescale 1ns/1ps
`default_nettype none
`include "mas_params.svh"
module mas_meas_engine
  import mas_pkg::*;
#(
  parameter int STAGE_CYC = `MAS_STAGE_CYC
) (
  input  wire logic  clk,
  input  wire logic  nrst,
  input  wire logic  index_in,
  input  wire logic [31:0] meas_data,
  mas_meas_if.eng    mif
);
  mas_eng_t    st_r;
  logic [1:0]  stage_r;
  logic [31:0] cnt_r;
  logic        last_cyc;

  assign last_cyc = (cnt_r == 32'(STAGE_CYC - 1));

  // Stage sequencing
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r    <= MAS_E_IDLE;
      stage_r <= 2'h0;
      cnt_r   <= 32'h0000_0000;
    end else begin
      case (st_r)
        MAS_E_IDLE: begin
          cnt_r   <= 32'h0000_0000;
          stage_r <= 2'h0;
          if (mif.start) begin
            st_r <= MAS_E_MEAS;
          end
        end
        MAS_E_MEAS: begin
          if (!mif.present[stage_r] || last_cyc) begin
            cnt_r <= 32'h0000_0000;
            if (stage_r == 2'h2) begin
              st_r <= MAS_E_END;
            end else begin
              stage_r <= stage_r + 2'h1;
            end
          end else begin
            cnt_r <= cnt_r + 32'h0000_0001;
          end
        end
        default: begin
          st_r <= MAS_E_IDLE;
        end
      endcase
    end
  end

  // Done pulse
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mif.done <= 1'b0;
    end else begin
      mif.done <= (st_r == MAS_E_END);
    end
  end

  // Index capture
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mif.index_found <= 1'b0;
    end else if (st_r == MAS_E_IDLE && mif.start) begin
      mif.index_found <= 1'b0;
    end else if (st_r == MAS_E_MEAS && index_in && mif.present[1]) begin
      mif.index_found <= 1'b1;
    end
  end

  // Stage results, absent feedback yields zero
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mif.result <= '0;
    end else if (st_r == MAS_E_MEAS) begin
      if (!mif.present[stage_r]) begin
        mif.result[stage_r] <= 32'h0000_0000;
      end else if (last_cyc) begin
        mif.result[stage_r] <= meas_data;
      end
    end
  end
endmodule : mas_meas_engine
`default_nettype wire

//--- verilog/mas_meas_if.sv
// Carrier between the sequencer and its measurement engine
`timescale 1ns/1ps
`default_nettype none
interface mas_meas_if;
  logic             start;
  logic [2:0]       present;
  logic             done;
  logic             index_found;
  logic [2:0][31:0] result;
  modport ctl (output start, output present, input done, input index_found, input result);
  modport eng (input start, input present, output done, output index_found, output result);
endinterface : mas_meas_if
`default_nettype wire

//--- verilog/mas_params.svh
// Offsets, field positions, reset values and timing counts of the auto setup sequencer
`ifndef MAS_PARAMS_SVH
`define MAS_PARAMS_SVH

`define MAS_ADDR_W           8
`define MAS_OFS_MODE         8'h00
`define MAS_OFS_CTRL         8'h04
`define MAS_OFS_STATUS       8'h08
`define MAS_OFS_PROG         8'h0C
`define MAS_OFS_RES0         8'h10
`define MAS_OFS_RES1         8'h14
`define MAS_OFS_RES2         8'h18
`define MAS_OFS_FBSEL        8'h1C
`define MAS_OFS_IRQ_STAT     8'h20
`define MAS_OFS_IRQ_MASK     8'h24
`define MAS_OFS_ERR_HIST     8'h28
`define MAS_OFS_CFG0         8'h30
`define MAS_OFS_CFG1         8'h34
`define MAS_OFS_CFG2         8'h38

`define MAS_MODE_AUTOSETUP   8'hFE
`define MAS_CW_OMS_BIT       4
`define MAS_SW_FAULT_BIT     3
`define MAS_SW_INDEX_BIT     10
`define MAS_SW_DONE_BIT      12
`define MAS_PROG_RUN_BIT     0
`define MAS_STORE_DRIVE_BIT  5
`define MAS_STORE_TUNE_BIT   6
`define MAS_IRQ_DONE_BIT     0
`define MAS_IRQ_ERR_BIT      1

`define MAS_RES_RST          32'h0000_0001
`define MAS_FBSEL_RST        8'h00
`define MAS_ERR_CODE_BASE    16'h7300

`define MAS_CLK_MHZ          50
`define MAS_CHECK_US         200
`define MAS_CHECK_CYC        (`MAS_CHECK_US * `MAS_CLK_MHZ)
`define MAS_STAGE_US         100
`define MAS_STAGE_CYC        (`MAS_STAGE_US * `MAS_CLK_MHZ)

`endif

//--- verilog/mas_pkg.sv
// Types shared by the auto setup sequencer modules
package mas_pkg;
  typedef enum logic [1:0] {
    MAS_IDLE,
    MAS_RUN,
    MAS_STORE
  } mas_seq_t;

  typedef enum logic [1:0] {
    MAS_E_IDLE,
    MAS_E_MEAS,
    MAS_E_END
  } mas_eng_t;

  typedef enum logic [1:0] {
    MAS_C_WAIT,
    MAS_C_CHECK,
    MAS_C_DONE
  } mas_chk_t;
endpackage : mas_pkg

//--- verilog/mas_sensor_check.sv
// Power-up check of every configured feedback sensor
`timescale 1ns/1ps
`default_nettype none
`include "mas_params.svh"
module mas_sensor_check
  import mas_pkg::*;
#(
  parameter int CHECK_CYC = `MAS_CHECK_CYC
) (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic [2:0] present,
  input  wire logic [2:0] sig_ok,
  input  wire logic [2:0] cfg_bad,
  output logic            err_pulse,
  output logic [15:0]     err_code
);
  mas_chk_t    st_r;
  logic [31:0] cnt_r;
  logic [2:0]  bad;
  logic [1:0]  first;

  // Absent sensors never count as faulty
  assign bad = present & (~sig_ok | cfg_bad);

  always_comb begin
    first = 2'h0;
    if (bad[0]) begin
      first = 2'h0;
    end else if (bad[1]) begin
      first = 2'h1;
    end else if (bad[2]) begin
      first = 2'h2;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r      <= MAS_C_WAIT;
      cnt_r     <= 32'h0000_0000;
      err_pulse <= 1'b0;
      err_code  <= 16'h0000;
    end else begin
      err_pulse <= 1'b0;
      case (st_r)
        MAS_C_WAIT: begin
          cnt_r <= cnt_r + 32'h0000_0001;
          if (cnt_r == 32'(CHECK_CYC - 1)) begin
            st_r <= MAS_C_CHECK;
          end
        end
        MAS_C_CHECK: begin
          st_r <= MAS_C_DONE;
          if (|bad) begin
            err_pulse <= 1'b1;
            err_code  <= `MAS_ERR_CODE_BASE + {14'h0000, first};
          end
        end
        default: begin
          st_r <= MAS_C_DONE;
        end
      endcase
    end
  end
endmodule : mas_sensor_check
`default_nettype wire

//--- verilog/mas_sequencer.sv
// Auto setup sequencer top: registers, run control, status, feedback bookkeeping
`timescale 1ns/1ps
`default_nettype none
`include "mas_params.svh"

module mas_sequencer
  import mas_pkg::*;
#(
  parameter int CHECK_CYC = `MAS_CHECK_CYC,
  parameter int STAGE_CYC = `MAS_STAGE_CYC
) (
  input  wire logic        CLK,
  input  wire logic        NRST,
  input  wire logic [7:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [31:0] RDATA,
  input  wire logic        OP_ENABLED,
  input  wire logic        INDEX_PIN,
  input  wire logic [2:0]  SENSOR_OK_PIN,
  input  wire logic [31:0] MEAS_DATA,
  output logic             STORE_REQ,
  output logic      [7:0]  STORE_SUBIDX,
  output logic      [1:0]  COMMUT_SEL,
  output logic      [1:0]  VEL_SEL,
  output logic      [1:0]  POS_SEL,
  output logic      [1:0]  OL_SEL,
  output logic             IRQ
);
  mas_meas_if  mif ();
  mas_seq_t    st_r;
  logic [7:0]  mode_r;
  logic [15:0] ctrl_r;
  logic        oms_d_r;
  logic        prog_r;
  logic [2:0][31:0] res_r;
  logic [2:0][31:0] cfg_r;
  logic [7:0]  fbsel_r;
  logic [1:0]  irq_stat_r;
  logic [1:0]  irq_mask_r;
  logic [15:0] err_hist_r;
  logic        done_r;
  logic        index_r;
  logic        fault_r;
  logic [3:0]  s1_r;
  logic [3:0]  s2_r;
  logic [3:0]  s3_r;
  logic [3:0]  pin_r;
  logic [3:0]  pin_in;
  logic [2:0]  present;
  logic        start;
  logic        err_pulse;
  logic [15:0] err_code;
  logic [31:0] rd_nxt;
  logic [15:0] status;
  logic [2:0]  cfg_bad;

  assign present = {|res_r[2], |res_r[1], |res_r[0]};
  assign cfg_bad = 3'h0;

  // Start on bit 4 rising edge
  assign start = (st_r == MAS_IDLE) && (mode_r == `MAS_MODE_AUTOSETUP) && OP_ENABLED
                 && !prog_r && ctrl_r[`MAS_CW_OMS_BIT] && !oms_d_r;
  assign mif.start   = (st_r == MAS_IDLE) && start;
  assign mif.present = present;
  // Pin synchronisers, value moves when stages two and three agree
  assign pin_in = {SENSOR_OK_PIN, INDEX_PIN};
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
          s1_r[gi]  <= 1'b0;
          s2_r[gi]  <= 1'b0;
          s3_r[gi]  <= 1'b0;
          pin_r[gi] <= 1'b0;
        end else begin
          s1_r[gi] <= pin_in[gi];
          s2_r[gi] <= s1_r[gi];
          s3_r[gi] <= s2_r[gi];
          if (s2_r[gi] == s3_r[gi]) begin
            pin_r[gi] <= s3_r[gi];
          end
        end
      end
    end
  endgenerate

  mas_meas_engine #(
    .STAGE_CYC (STAGE_CYC)
  ) mas_meas_engine_inst (
    .clk       (CLK),
    .nrst      (NRST),
    .index_in  (pin_r[0]),
    .meas_data (MEAS_DATA),
    .mif       (mif.eng)
  );

  mas_sensor_check #(
    .CHECK_CYC (CHECK_CYC)
  ) mas_sensor_check_inst (
    .clk       (CLK),
    .nrst      (NRST),
    .present   (present),
    .sig_ok    (pin_r[3:1]),
    .cfg_bad   (cfg_bad),
    .err_pulse (err_pulse),
    .err_code  (err_code)
  );

  // Run sequencing
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      st_r <= MAS_IDLE;
    end else begin
      case (st_r)
        MAS_IDLE: begin
          if (start) begin
            st_r <= MAS_RUN;
          end
        end
        MAS_RUN: begin
          if (mif.done) begin
            st_r <= MAS_STORE;
          end
        end
        default: begin
          st_r <= MAS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      oms_d_r <= 1'b0;
    end else begin
      oms_d_r <= ctrl_r[`MAS_CW_OMS_BIT];
    end
  end

  // Completion and index status
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      done_r  <= 1'b0;
      index_r <= 1'b0;
    end else if (st_r == MAS_STORE) begin
      done_r  <= 1'b1;
      index_r <= mif.index_found;
    end else if (start) begin
      done_r  <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      STORE_REQ    <= 1'b0;
      STORE_SUBIDX <= 8'h00;
    end else begin
      STORE_REQ    <= (st_r == MAS_STORE);
      if (st_r == MAS_STORE) begin
        STORE_SUBIDX <= 8'h00;
        STORE_SUBIDX[`MAS_STORE_DRIVE_BIT] <= 1'b1;
        STORE_SUBIDX[`MAS_STORE_TUNE_BIT]  <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      cfg_r <= '0;
    end else if (st_r == MAS_STORE) begin
      cfg_r <= mif.result;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      fault_r    <= 1'b0;
      err_hist_r <= 16'h0000;
    end else if (err_pulse) begin
      fault_r    <= 1'b1;
      err_hist_r <= err_code;
    end
  end

  // Software written registers
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      mode_r     <= 8'h00;
      ctrl_r     <= 16'h0000;
      prog_r     <= 1'b0;
      res_r      <= {`MAS_RES_RST, `MAS_RES_RST, `MAS_RES_RST};
      fbsel_r    <= `MAS_FBSEL_RST;
      irq_mask_r <= 2'h0;
    end else if (WR) begin
      if (ADDR == `MAS_OFS_MODE) begin
        mode_r <= WDATA[7:0];
      end else if (ADDR == `MAS_OFS_CTRL) begin
        ctrl_r <= WDATA[15:0];
      end else if (ADDR == `MAS_OFS_PROG) begin
        prog_r <= WDATA[0];
      end else if (ADDR == `MAS_OFS_RES0) begin
        res_r[0] <= WDATA;
      end else if (ADDR == `MAS_OFS_RES1) begin
        res_r[1] <= WDATA;
      end else if (ADDR == `MAS_OFS_RES2) begin
        res_r[2] <= WDATA;
      end else if (ADDR == `MAS_OFS_FBSEL) begin
        fbsel_r <= WDATA[7:0];
      end else if (ADDR == `MAS_OFS_IRQ_MASK) begin
        irq_mask_r <= WDATA[1:0];
      end
    end
  end

  // Sticky events, set wins over write-one clear
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      irq_stat_r <= 2'h0;
    end else begin
      if (WR && ADDR == `MAS_OFS_IRQ_STAT) begin
        irq_stat_r <= irq_stat_r & ~WDATA[1:0];
      end
      if (st_r == MAS_STORE) begin
        irq_stat_r[`MAS_IRQ_DONE_BIT] <= 1'b1;
      end
      if (err_pulse) begin
        irq_stat_r[`MAS_IRQ_ERR_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(irq_stat_r & irq_mask_r);
    end
  end

  // Loop feedback selection, absent feedback gives none
  function automatic logic [1:0] pick(input logic [1:0] sel, input logic [2:0] pres);
    pick = 2'h0;
    if (sel != 2'h0 && pres[sel - 2'h1]) begin
      pick = sel;
    end
  endfunction : pick

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      COMMUT_SEL <= 2'h0;
      VEL_SEL    <= 2'h0;
      POS_SEL    <= 2'h0;
      OL_SEL     <= 2'h0;
    end else begin
      COMMUT_SEL <= pick(fbsel_r[1:0], present);
      VEL_SEL    <= pick(fbsel_r[3:2], present);
      POS_SEL    <= pick(fbsel_r[5:4], present);
      OL_SEL     <= pick(fbsel_r[7:6], present);
    end
  end

  always_comb begin
    status = 16'h0000;
    status[`MAS_SW_FAULT_BIT] = fault_r;
    status[`MAS_SW_INDEX_BIT] = index_r;
    status[`MAS_SW_DONE_BIT]  = done_r;
  end

  // Read decode, unmapped reads zero
  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (ADDR == `MAS_OFS_MODE) begin
      rd_nxt = {24'h00_0000, mode_r};
    end else if (ADDR == `MAS_OFS_CTRL) begin
      rd_nxt = {16'h0000, ctrl_r};
    end else if (ADDR == `MAS_OFS_STATUS) begin
      rd_nxt = {16'h0000, status};
    end else if (ADDR == `MAS_OFS_PROG) begin
      rd_nxt = {31'h0000_0000, prog_r};
    end else if (ADDR == `MAS_OFS_RES0) begin
      rd_nxt = res_r[0];
    end else if (ADDR == `MAS_OFS_RES1) begin
      rd_nxt = res_r[1];
    end else if (ADDR == `MAS_OFS_RES2) begin
      rd_nxt = res_r[2];
    end else if (ADDR == `MAS_OFS_FBSEL) begin
      rd_nxt = {24'h00_0000, fbsel_r};
    end else if (ADDR == `MAS_OFS_IRQ_STAT) begin
      rd_nxt = {30'h0000_0000, irq_stat_r};
    end else if (ADDR == `MAS_OFS_IRQ_MASK) begin
      rd_nxt = {30'h0000_0000, irq_mask_r};
    end else if (ADDR == `MAS_OFS_ERR_HIST) begin
      rd_nxt = {16'h0000, err_hist_r};
    end else if (ADDR == `MAS_OFS_CFG0) begin
      rd_nxt = cfg_r[0];
    end else if (ADDR == `MAS_OFS_CFG1) begin
      rd_nxt = cfg_r[1];
    end else if (ADDR == `MAS_OFS_CFG2) begin
      rd_nxt = cfg_r[2];
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      RDATA <= 32'h0000_0000;
    end else if (RD) begin
      RDATA <= rd_nxt;
    end else begin
      RDATA <= 32'h0000_0000;
    end
  end
endmodule : mas_sequencer
`default_nettype wire
